/* File: cpps_deglitch.sv */
// clearing deglitch counter: output follows input once it has held
// assumes a synchronised input
`timescale 1ns/10ps
module cpps_deglitch #(
  parameter int COUNT = 250
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // level
  input  wire logic level_i,
  output logic      level_o
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          out_reg;
  logic          out_next;

  initial begin
    if (COUNT < 1) $error("cpps_deglitch: count must be at least one");
  end

  // counter clears when the output takes the new level, so it never wraps
  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (level_i == out_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == CW'(COUNT - 1)) begin
      out_next = level_i;
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign level_o = out_reg;

endmodule // cpps_deglitch

/* File: cpps_host_model.sv */
// host processor model driving the control pins
// assumes requests change just after a clock edge
`timescale 1ns/10ps
module cpps_host_model
  import cpps_pkg::*;
(
  // clock
  input  wire logic       ref_clk_i,
  // request and its lag in cycles
  input  wire cpps_ctrl_t want_i,
  input  wire logic [3:0] lag_i,
  // pins toward the device
  output cpps_ctrl_t      ctrl_o
);
  // pins follow late, like a slow firmware loop
  logic [3:0] wait_reg;
  initial begin
    wait_reg = 4'h0;
    ctrl_o = '0;
  end
  always @(posedge ref_clk_i) begin
    if (want_i == ctrl_o)
      wait_reg <= 4'h0;
    else if (wait_reg >= lag_i)
      ctrl_o <= want_i;
    else
      wait_reg <= wait_reg + 4'h1;
  end
endmodule // cpps_host_model

/* File: cpps_pkg.sv */
// types shared by the charger power path sequencer files
// assumes the constants header is included where numbers are needed
package cpps_pkg;

  typedef enum logic [1:0] {
    CPPS_INPUT_LIMIT_RESISTOR_PIN_START,
    CPPS_INPUT_LIMIT_RESISTOR_PIN_LOW,
    CPPS_INPUT_LIMIT_RESISTOR_PIN_HIGH,
    CPPS_INPUT_LIMIT_RESISTOR_PIN_RES
  } cpps_input_limit_resistor_pin_t;

  // comparator flags from the analog front end
  typedef struct packed {
    logic lockout;
    logic headroom;
    logic overvoltage;
    logic out_short;
    logic out_overload;
    logic prog_short;
  } cpps_flags_t;

  // host control pins
  typedef struct packed {
    logic charge_enable_low;
    logic limit_select_a;
    logic limit_select_b;
    logic battery_disconnect;
  } cpps_ctrl_t;

endpackage

/* File: cpps_regs.svh */
// constants for the charger power path sequencer
// assumes a 250 MHz core clock; counts derive from times in ns
`ifndef CPPS_REGS_SVH
`define CPPS_REGS_SVH

`define CPPS_CLK_PERIOD_NS     4
// --------------------------------------------------------------
// deglitch and recovery times
// --------------------------------------------------------------
`define CPPS_OVP_DGL_NS        1000
`define CPPS_OVP_DGL_CYC       (`CPPS_OVP_DGL_NS / `CPPS_CLK_PERIOD_NS)
`define CPPS_SC2_DGL_NS        1000
`define CPPS_SC2_DGL_CYC       (`CPPS_SC2_DGL_NS / `CPPS_CLK_PERIOD_NS)
`define CPPS_SC2_REC_NS        16000
`define CPPS_SC2_REC_CYC       (`CPPS_SC2_REC_NS / `CPPS_CLK_PERIOD_NS)
`define CPPS_SYNC_STAGES       2
// --------------------------------------------------------------
// input limit encodings on the limit pins
// --------------------------------------------------------------
`define CPPS_LIM_LOW           2'h0
`define CPPS_LIM_HIGH          2'h1
`define CPPS_LIM_RES           2'h2
`define CPPS_LIM_SUSP          2'h3

`endif

/* File: cpps_sequencer.sv */
// power path start-up sequencer of a battery charger
// assumes flags from analog comparators and host pins, all asynchronous
`timescale 1ns/10ps
`include "cpps_regs.svh"

module cpps_sequencer
  import cpps_pkg::*;
#(
  parameter int OVP_DGL_CYC = `CPPS_OVP_DGL_CYC,
  parameter int SC2_DGL_CYC = `CPPS_SC2_DGL_CYC,
  parameter int SC2_REC_CYC = `CPPS_SC2_REC_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // analog comparator flags
  input  wire cpps_flags_t flags_i,
  input  wire logic        battery_present_i,
  // host control pins
  input  wire cpps_ctrl_t  ctrl_i,
  // power switches
  output logic             input_pass_switch_o,
  output cpps_input_limit_resistor_pin_t       input_limit_o,
  output logic             battery_path_switch_o,
  output logic             output_path_active_o,
  output logic             overload_monitor_en_o,
  // internal enables
  output logic             blocks_active_o,
  output logic             charge_enable_o,
  output logic             timer_reset_o,
  // open-drain status pins
  output logic             power_valid_low_out_o,
  output logic             power_valid_low_oe_o,
  output logic             charge_status_low_out_o,
  output logic             charge_status_low_oe_o
);

  // --------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------
  initial begin
    if (OVP_DGL_CYC < 1 || SC2_DGL_CYC < 1 || SC2_REC_CYC < 1)
      $error("cpps_sequencer: counts must be at least one");
    if (`CPPS_SYNC_STAGES != 2)
      $error("cpps_sequencer: synchroniser depth is fixed at two");
  end

  // --------------------------------------------------------------
  // input conditioning
  // --------------------------------------------------------------
  localparam int NSYNC = $bits(cpps_flags_t) + $bits(cpps_ctrl_t) + 1;

  logic [NSYNC-1:0] sync_bus;
  cpps_flags_t      flg;
  cpps_ctrl_t       ctl;
  logic             batt_present;
  logic             ovp_dgl;
  logic             ovl_dgl;

  cpps_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({flags_i, ctrl_i, battery_present_i}),
    .sync_o    (sync_bus)
  );

  assign {flg, ctl, batt_present} = sync_bus;

  cpps_deglitch #(
    .COUNT (OVP_DGL_CYC)
  ) u_ovp_dgl (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .level_i   (flg.overvoltage),
    .level_o   (ovp_dgl)
  );

  cpps_deglitch #(
    .COUNT (SC2_DGL_CYC)
  ) u_ovl_dgl (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .level_i   (flg.out_overload),
    .level_o   (ovl_dgl)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic suspend_sel(input cpps_ctrl_t c);
    return c.limit_select_a & c.limit_select_b;
  endfunction

  function automatic cpps_input_limit_resistor_pin_t limit_of(input cpps_ctrl_t c);
    case ({c.limit_select_b, c.limit_select_a})
      `CPPS_LIM_LOW:  limit_of = CPPS_INPUT_LIMIT_RESISTOR_PIN_LOW;
      `CPPS_LIM_HIGH: limit_of = CPPS_INPUT_LIMIT_RESISTOR_PIN_HIGH;
      default:        limit_of = CPPS_INPUT_LIMIT_RESISTOR_PIN_RES;
    endcase
  endfunction

  // --------------------------------------------------------------
  // start-up hold
  // --------------------------------------------------------------
  // synchroniser flops clear to zero, which reads as input above
  // lockout; hold power-down until real levels have come through,
  // else the machine leaves power-down for a cycle or two
  localparam int PW = $clog2(`CPPS_SYNC_STAGES + 1);

  logic [PW-1:0] prime_cnt_reg;
  logic [PW-1:0] prime_cnt_next;
  logic          primed;

  always_comb begin
    prime_cnt_next = prime_cnt_reg;
    if (prime_cnt_reg != PW'(`CPPS_SYNC_STAGES)) begin
      prime_cnt_next = prime_cnt_reg + PW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prime_cnt_reg <= '0;
    end else begin
      prime_cnt_reg <= prime_cnt_next;
    end
  end

  assign primed = (prime_cnt_reg == PW'(`CPPS_SYNC_STAGES));

  // --------------------------------------------------------------
  // main state machine
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_DOWN,
    ST_HEADROOM_WAIT,
    ST_STANDBY,
    ST_PROG_CHECK,
    ST_OUT_SHORT_TEST,
    ST_NORMAL,
    ST_OVERVOLT
  } cpps_state_t;

  cpps_state_t state_reg;
  cpps_state_t state_next;
  cpps_input_limit_resistor_pin_t  limit_reg;
  cpps_input_limit_resistor_pin_t  limit_next;
  logic        ovp_seen_reg;
  logic        ovp_seen_next;
  logic        tmr_rst_reg;
  logic        tmr_rst_next;

  always_comb begin
    state_next    = state_reg;
    limit_next    = limit_reg;
    ovp_seen_next = ovp_seen_reg;
    tmr_rst_next  = 1'b0;
    // unprimed inputs count as lockout
    if (flg.lockout || !primed) begin
      state_next = ST_POWER_DOWN;
    end else begin
      case (state_reg)
        ST_POWER_DOWN: begin
          // control pins not looked at here
          state_next = ST_HEADROOM_WAIT;
        end
        ST_HEADROOM_WAIT: begin
          if (flg.headroom) begin
            state_next = ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!flg.headroom) begin
            state_next = ST_HEADROOM_WAIT;
          end else if (ovp_dgl) begin
            state_next = ST_OVERVOLT;
          end else if (!suspend_sel(ctl) && !flg.overvoltage) begin
            state_next = ST_PROG_CHECK;
          end
        end
        ST_PROG_CHECK: begin
          if (!flg.headroom || flg.overvoltage || suspend_sel(ctl)) begin
            state_next = ST_STANDBY;
          end else if (!flg.prog_short) begin
            limit_next = CPPS_INPUT_LIMIT_RESISTOR_PIN_START;
            state_next = ST_OUT_SHORT_TEST;
          end
        end
        ST_OUT_SHORT_TEST: begin
          if (!flg.headroom || flg.overvoltage || suspend_sel(ctl)) begin
            state_next = ST_STANDBY;
          end else if (!flg.out_short) begin
            limit_next = limit_of(ctl);
            state_next = ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          limit_next = limit_of(ctl);
          if (ovp_dgl) begin
            state_next = ST_OVERVOLT;
          end else if (!flg.headroom) begin
            state_next = ST_HEADROOM_WAIT;
          end else if (suspend_sel(ctl)) begin
            state_next = ST_STANDBY;
          end
        end
        ST_OVERVOLT: begin
          ovp_seen_next = 1'b1;
          if (!ovp_dgl) begin
            tmr_rst_next = 1'b1;
            state_next   = ST_HEADROOM_WAIT;
          end
        end
        default: begin
          state_next = ST_POWER_DOWN;
        end
      endcase
    end
    // fresh cycle shown until normal operation is reached again with charging enabled
    if (state_reg == ST_NORMAL && ctl.charge_enable_low == 1'b0) begin
      ovp_seen_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg    <= ST_POWER_DOWN;
      limit_reg    <= CPPS_INPUT_LIMIT_RESISTOR_PIN_START;
      ovp_seen_reg <= 1'b0;
      tmr_rst_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      limit_reg    <= limit_next;
      ovp_seen_reg <= ovp_seen_next;
      tmr_rst_reg  <= tmr_rst_next;
    end
  end

  // --------------------------------------------------------------
  // output overload hiccup
  // --------------------------------------------------------------
  localparam int RW = $clog2(SC2_REC_CYC + 1);

  logic          ovl_off_reg;
  logic          ovl_off_next;
  logic [RW-1:0] rec_cnt_reg;
  logic [RW-1:0] rec_cnt_next;

  // trips only while the input switch is off: with the input on,
  // the output is fed through the input limit instead
  // retry blindly: a stuck short keeps cycling off and on
  always_comb begin
    ovl_off_next = ovl_off_reg;
    rec_cnt_next = rec_cnt_reg;
    if (ovl_off_reg) begin
      if (rec_cnt_reg == RW'(SC2_REC_CYC - 1)) begin
        ovl_off_next = 1'b0;
        rec_cnt_next = '0;
      end else begin
        rec_cnt_next = rec_cnt_reg + RW'(1);
      end
    end else if (ovl_dgl && overload_monitor_en_o) begin
      ovl_off_next = 1'b1;
      rec_cnt_next = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ovl_off_reg <= 1'b0;
      rec_cnt_reg <= '0;
    end else begin
      ovl_off_reg <= ovl_off_next;
      rec_cnt_reg <= rec_cnt_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  logic in_off;
  logic pv_drive;
  logic running;

  assign in_off = (state_reg == ST_POWER_DOWN) ||
                  (state_reg == ST_HEADROOM_WAIT) ||
                  (state_reg == ST_STANDBY) ||
                  (state_reg == ST_PROG_CHECK) ||
                  (state_reg == ST_OVERVOLT);
  assign running = (state_reg == ST_PROG_CHECK) ||
                   (state_reg == ST_OUT_SHORT_TEST) ||
                   (state_reg == ST_NORMAL);
  assign pv_drive = running || (state_reg == ST_STANDBY);

  assign input_pass_switch_o   = ~in_off;
  assign input_limit_o         = limit_reg;
  assign battery_path_switch_o = in_off & ~ctl.battery_disconnect &
                                 ~ovl_off_reg;
  assign overload_monitor_en_o = in_off;
  // the input switch feeds the output on its own; the hiccup
  // only cuts the battery-fed path that it watches
  assign output_path_active_o  = ~in_off |
                                 (~ovl_off_reg & batt_present &
                                  ~ctl.battery_disconnect);
  assign blocks_active_o       = running;
  assign charge_enable_o       = (state_reg == ST_NORMAL) &
                                 ~ctl.charge_enable_low;
  assign timer_reset_o         = tmr_rst_reg;

  // open-drain: low when driven, released otherwise
  // charge status also flags a fresh cycle after overvoltage
  assign power_valid_low_out_o   = 1'b0;
  assign power_valid_low_oe_o    = pv_drive;
  assign charge_status_low_out_o = 1'b0;
  assign charge_status_low_oe_o  = charge_enable_o | 
                                   (ovp_seen_reg & running);

endmodule // cpps_sequencer

/* File: cpps_sequencer_asserts.sv */
// port checker for the power path sequencer
// assumes one clock domain with a synchronous reset
`timescale 1ns/10ps
module cpps_sequencer_asserts
  import cpps_pkg::*;
#(
  parameter int OVP_DGL_CYC = 4
) (
  // clock, reset and inputs
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire cpps_flags_t flags_i,
  input wire cpps_ctrl_t  ctrl_i,
  input wire logic        battery_present_i,
  // outputs watched
  input wire logic        input_pass_switch_o,
  input wire logic        battery_path_switch_o,
  input wire logic        output_path_active_o,
  input wire logic        overload_monitor_en_o,
  input wire logic        blocks_active_o,
  input wire logic        charge_enable_o,
  input wire logic        timer_reset_o,
  input wire logic        power_valid_low_out_o,
  input wire logic        power_valid_low_oe_o,
  input wire logic        charge_status_low_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // --------------------------------------------
  // overvoltage age, saturating at 255
  // --------------------------------------------
  logic [7:0] ovp_reg;
  logic [7:0] ovp_next;
  always_comb begin
    ovp_next = ovp_reg;
    if (!flags_i.overvoltage)
      ovp_next = 8'h00;
    else if (ovp_reg != 8'hff)
      ovp_next = ovp_reg + 8'h01;
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i)
      ovp_reg <= 8'h00;
    else
      ovp_reg <= ovp_next;
  end
  // sync and state add up to three edges
  sequence lock_s;
    flags_i.lockout[*4];
  endsequence
  sequence susp_s;
    (ctrl_i.limit_select_a && ctrl_i.limit_select_b)[*4];
  endsequence
  sequence ovp_s;
    ovp_reg > 8'(OVP_DGL_CYC + 6);
  endsequence
  pd_outputs_a: assert property (
    lock_s |-> !input_pass_switch_o && !power_valid_low_oe_o
      && !charge_status_low_oe_o)
    else $error("input on or status driven in lockout");
  susp_off_a: assert property (
    susp_s |-> !input_pass_switch_o)
    else $error("input on with suspend selected");
  pv_level_a: assert property (
    power_valid_low_oe_o |-> !power_valid_low_out_o)
    else $error("power valid driven high");
  monitor_on_a: assert property (
    !input_pass_switch_o |-> overload_monitor_en_o)
    else $error("overload monitor idle with input off");
  act_gate_a: assert property (
    input_pass_switch_o |-> blocks_active_o)
    else $error("input on with blocks inactive");
  chg_gate_a: assert property (
    charge_enable_o |-> input_pass_switch_o)
    else $error("charging with input off");
  ovp_off_a: assert property (
    ovp_s |-> !input_pass_switch_o && !power_valid_low_oe_o
      && !charge_enable_o)
    else $error("overvoltage left input or status on");
  path_on_a: assert property (
    (input_pass_switch_o || (battery_path_switch_o && battery_present_i))[*3]
      |-> output_path_active_o)
    else $error("output path off with a source");
  timer_pulse_a: assert property (
    $rose(timer_reset_o) |=> !timer_reset_o ##[0:2]
      charge_status_low_oe_o)
    else $error("timer reset not a pulse or no new cycle");
endmodule // cpps_sequencer_asserts

bind cpps_sequencer cpps_sequencer_asserts #(
  .OVP_DGL_CYC(OVP_DGL_CYC)
) u_asserts (
  .ref_clk_i,
  .reset_i,
  .flags_i,
  .ctrl_i,
  .battery_present_i,
  .input_pass_switch_o,
  .battery_path_switch_o,
  .output_path_active_o,
  .overload_monitor_en_o,
  .blocks_active_o,
  .charge_enable_o,
  .timer_reset_o,
  .power_valid_low_out_o,
  .power_valid_low_oe_o,
  .charge_status_low_oe_o
);

/* File: cpps_sync.sv */
// two-stage synchroniser for a bundle of level inputs
// assumes inputs are slow levels; no pulses shorter than a clock
`timescale 1ns/10ps
module cpps_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  initial begin
    if (WIDTH < 1) $error("cpps_sync: width must be positive");
  end

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule // cpps_sync

/* File: tb_charger_power_path_sequencer.sv */
// testbench for the power path sequencer
// assumes the host model drives the control pins
`timescale 1ns/10ps
module tb_charger_power_path_sequencer
  import cpps_pkg::*;
();
  localparam int OVERVOLTAGE_FLAG = 4;
  localparam int DGL = 4;
  localparam int REC = 12;
  logic        ref_clk;
  logic        reset;
  cpps_flags_t flags;
  cpps_ctrl_t  want;
  cpps_ctrl_t  ctrl;
  logic [3:0]  lag;
  logic [3:0]  cnt;
  logic [1:0]  sel;
  logic        ce;
  logic        batt;
  logic        pass, bsw, opath, mon, act, charge_status_low, trst, pv_oe, cs_oe;
  cpps_input_limit_resistor_pin_t  lim;
  int          errors, num_checks, seed, i;

  cpps_sequencer #(
    .OVP_DGL_CYC(OVERVOLTAGE_FLAG),
    .SC2_DGL_CYC(DGL),
    .SC2_REC_CYC(REC)
  ) DUT (
    .ref_clk_i(ref_clk),
    .reset_i(reset),
    .flags_i(flags),
    .battery_present_i(batt),
    .ctrl_i(ctrl),
    .input_pass_switch_o(pass),
    .input_limit_o(lim),
    .battery_path_switch_o(bsw),
    .output_path_active_o(opath),
    .overload_monitor_en_o(mon),
    .blocks_active_o(act),
    .charge_enable_o(charge_status_low),
    .timer_reset_o(trst),
    .power_valid_low_out_o(),
    .power_valid_low_oe_o(pv_oe),
    .charge_status_low_out_o(),
    .charge_status_low_oe_o(cs_oe)
  );
  cpps_host_model u_host (
    .ref_clk_i(ref_clk),
    .want_i(want),
    .lag_i(lag),
    .ctrl_o(ctrl)
  );

  always #2 ref_clk = ~ref_clk;

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string what, input logic [3:0] seen,
                     input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic cpps_input_limit_resistor_pin_t lim_of(input logic [1:0] s);
    if (s == 2'h0)
      return CPPS_INPUT_LIMIT_RESISTOR_PIN_LOW;
    return (s == 2'h1) ? CPPS_INPUT_LIMIT_RESISTOR_PIN_HIGH : CPPS_INPUT_LIMIT_RESISTOR_PIN_RES;
  endfunction
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard well past the expected run
  initial begin
    #160000;
    errors++;
    end_of_test();
  end

  initial begin
    ref_clk = 1'b0;
    seed = 83;
    batt = 1'b1;
    flags = 6'h24;
    want = 4'h0;
    lag = 4'h0;
    reset = 1'b1;
    step(16);
    reset <= 1'b0;
    want <= 4'h6;
    step(12);
    chk("pass_pd", pass, 4'h0);
    chk("pv_pd", pv_oe, 4'h0);
    chk("cs_pd", cs_oe, 4'h0);
    chk("bsw_pd", bsw, 4'h1);
    chk("mon_pd", mon, 4'h1);
    chk("path_pd", opath, 4'h1);
    flags.lockout <= 1'b0;
    step(10);
    chk("pass_wait", pass, 4'h0);
    chk("pv_wait", pv_oe, 4'h0);
    flags.headroom <= 1'b1;
    want.battery_disconnect <= 1'b1;
    step(12);
    chk("pv_stby", pv_oe, 4'h1);
    chk("pass_stby", pass, 4'h0);
    chk("bsw_disc", bsw, 4'h0);
    want <= 4'h0;
    step(12);
    chk("pass_test", pass, 4'h1);
    chk("lim_test", lim, CPPS_INPUT_LIMIT_RESISTOR_PIN_START);
    chk("act", act, 4'h1);
    flags.out_short <= 1'b0;
    // first four walk every select code, then random
    for (i = 0; i < 14; i++) begin
      sel = (i < 4) ? i[1:0] : 2'($random(seed));
      ce = 1'($random(seed));
      lag <= 4'($random(seed));
      want <= {ce, sel[0], sel[1], 1'b0};
      step(30);
      if (sel == 2'h3)
        chk("pass_susp", pass, 4'h0);
      else begin
        chk("lim_sel", lim, lim_of(sel));
        chk("chg_sel", charge_status_low, {3'h0, ~ce});
        chk("cs_sel", cs_oe, {3'h0, ~ce});
      end
    end
    want <= 4'h0;
    flags.prog_short <= 1'b1;
    flags.lockout <= 1'b1;
    step(10);
    flags.lockout <= 1'b0;
    step(20);
    chk("pass_prog", pass, 4'h0);
    flags.prog_short <= 1'b0;
    step(20);
    chk("pass_noprog", pass, 4'h1);
    flags.overvoltage <= 1'b1;
    step(OVERVOLTAGE_FLAG + 12);
    chk("pass_ovp", pass, 4'h0);
    chk("chg_ovp", charge_status_low, 4'h0);
    chk("pv_ovp", pv_oe, 4'h0);
    chk("bsw_ovp", bsw, 4'h1);
    flags.overvoltage <= 1'b0;
    cnt = 4'h0;
    repeat (20) begin
      step(1);
      if (trst === 1'b1)
        cnt++;
    end
    chk("trst", cnt, 4'h1);
    step(10);
    chk("pass_back", pass, 4'h1);
    chk("cs_back", cs_oe, 4'h1);
    flags.lockout <= 1'b1;
    flags.out_overload <= 1'b1;
    step(DGL + 8);
    chk("bsw_ovl", bsw, 4'h0);
    chk("path_ovl", opath, 4'h0);
    cnt = 4'h0;
    repeat (3 * REC) begin
      step(1);
      if (bsw === 1'b1 && cnt != 4'hf)
        cnt++;
    end
    chk("retry", {3'h0, cnt != 4'h0}, 4'h1);
    flags.out_overload <= 1'b0;
    step(REC + 12);
    chk("bsw_clr", bsw, 4'h1);
    batt <= 1'b0;
    step(6);
    chk("path_nobatt", opath, 4'h0);
    chk("bsw_nobatt", bsw, 4'h1);
    end_of_test();
  end
endmodule // tb_charger_power_path_sequencer
